// ---- rtl/sbsel_pkg.sv ----
// package: constants, register map and types of the settings bank selector
package sbsel_pkg;
    localparam int SBSEL_AW = 4;
    localparam logic [SBSEL_AW-1:0] SBSEL_CTRL_ADDR = 4'h0;
    localparam logic [SBSEL_AW-1:0] SBSEL_STAT_ADDR = 4'h1;
    localparam logic [SBSEL_AW-1:0] SBSEL_IRQ_ADDR = 4'h2;
    localparam logic [SBSEL_AW-1:0] SBSEL_MASK_ADDR = 4'h3;
    localparam logic [SBSEL_AW-1:0] SBSEL_PARAM_ADDR = 4'h4;
    // ctrl fields
    localparam int SBSEL_CTRL_STORED_LSB = 0;
    localparam int SBSEL_CTRL_EDIT_LSB = 2;
    localparam int SBSEL_CTRL_BRK_BIT = 4;
    localparam int SBSEL_CTRL_OC_BIT = 5;
    localparam int SBSEL_CTRL_OV_BIT = 6;
    localparam int SBSEL_CTRL_UV_BIT = 7;
    localparam int SBSEL_CTRL_UF_BIT = 8;
    localparam logic [8:0] SBSEL_CTRL_RST = 9'h000;
    // irq bits
    localparam int SBSEL_IRQ_CHANGE_BIT = 0;
    localparam int SBSEL_IRQ_HELD_BIT = 1;
    localparam logic [1:0] SBSEL_IRQ_RST = 2'h0;
    localparam logic [1:0] SBSEL_MASK_RST = 2'h0;
    // bank encoding: 0 is bank 1
    typedef logic [1:0] sbsel_bank_t;
    localparam sbsel_bank_t SBSEL_BANK1 = 2'h0;
    localparam int SBSEL_NBANK = 4;
    localparam int SBSEL_PW = 16;
endpackage

// ---- rtl/sbsel_mem.sv ----
// parameter memory: four banks of element settings, registered read
`timescale 1ns/1ps
`default_nettype none
module sbsel_mem
    import sbsel_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic ce_in, // clock enable
    input wire logic we_in, // write strobe
    input wire logic [1:0] waddr_in, // bank written
    input wire logic [SBSEL_PW-1:0] wdata_in, // write data
    input wire logic [1:0] raddr_in, // bank read
    output logic [SBSEL_PW-1:0] rdata_out // registered read data
);
    logic [SBSEL_PW-1:0] mem_r [SBSEL_NBANK];
    always_ff @(posedge clk_in)
    begin
        if (ce_in)
        begin
            if (we_in)
            begin
                mem_r[waddr_in] <= wdata_in;
            end
            rdata_out <= mem_r[raddr_in];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sbsel_top.sv ----
// settings bank selector with wishbone register slave
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sbsel_top
    import sbsel_pkg::*;
(
    input wire logic clk_in, // 200 MHz clock
    input wire logic nrst_in, // async reset, active low
    input wire logic ce_in, // clock enable
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [SBSEL_AW-1:0] wb_adr_i, // word address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic [2:0] bank_req_in, // bank 2..4 request pins
    input wire logic breaker_closed_in, // breaker state pin
    input wire logic oc_picked_in, // non-disabled overcurrent pickup
    input wire logic ov_picked_in, // non-disabled overvoltage pickup
    input wire logic uv_picked_in, // non-disabled undervoltage pickup
    input wire logic uf_picked_in, // non-disabled underfrequency pickup
    output logic [3:0] bank_led_out, // one-hot bank indicator
    output logic [SBSEL_PW-1:0] elem_param_out, // active bank parameters
    output logic event_out, // bank change event strobe
    output logic [1:0] event_bank_out, // new bank with event
    output logic irq_out // interrupt level
);
    import sbsel_pkg::*;

    // ****************************************
    // reset and input synchronisers
    // ****************************************
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    localparam int NPIN = 8;
    logic [NPIN-1:0] pin_raw, pin_s1_r, pin_s2_r;
    assign pin_raw = {uf_picked_in, uv_picked_in, ov_picked_in, oc_picked_in,
                      breaker_closed_in, bank_req_in};
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
        end
        else if (ce_in)
        begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end
    logic [2:0] req_s;
    logic brk_closed_s, oc_s, ov_s, uv_s, uf_s;
    assign req_s = pin_s2_r[2:0];
    assign brk_closed_s = pin_s2_r[3];
    assign oc_s = pin_s2_r[4];
    assign ov_s = pin_s2_r[5];
    assign uv_s = pin_s2_r[6];
    assign uf_s = pin_s2_r[7];

    // ****************************************
    // registers and wishbone slave
    // ****************************************
    logic [8:0] ctrl_r, ctrl_nxt;
    logic [1:0] irq_r, irq_nxt, mask_r, mask_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [1:0] active_r, active_nxt;
    logic pend_r, pend_nxt;
    logic change_ev, held_ev;
    logic hold, wb_acc, wb_wr;
    logic [1:0] target;
    logic [SBSEL_PW-1:0] mem_rdata;

    assign wb_acc = wb_cyc_i && wb_stb_i && !ack_r;
    assign wb_wr = wb_acc && wb_we_i;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        ack_nxt = wb_acc;
        dat_nxt = 32'h0000_0000;
        // set beats clear
        irq_nxt = irq_r;
        if (wb_wr && wb_adr_i == SBSEL_IRQ_ADDR && wb_sel_i[0])
            irq_nxt = irq_r & ~wb_dat_i[1:0];
        if (change_ev)
            irq_nxt[SBSEL_IRQ_CHANGE_BIT] = 1'b1;
        if (held_ev)
            irq_nxt[SBSEL_IRQ_HELD_BIT] = 1'b1;
        if (wb_wr && wb_adr_i == SBSEL_CTRL_ADDR)
        begin
            if (wb_sel_i[0])
                ctrl_nxt[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1])
                ctrl_nxt[8] = wb_dat_i[8];
        end
        if (wb_wr && wb_adr_i == SBSEL_MASK_ADDR && wb_sel_i[0])
            mask_nxt = wb_dat_i[1:0];
        if (wb_acc && !wb_we_i)
        begin
            unique case (wb_adr_i)
                SBSEL_CTRL_ADDR: dat_nxt = {23'h000000, ctrl_r};
                SBSEL_STAT_ADDR: dat_nxt = {20'h00000, pend_r, hold, pin_s2_r[7:3],
                                            req_s, active_r};
                SBSEL_IRQ_ADDR: dat_nxt = {30'h00000000, irq_r};
                SBSEL_MASK_ADDR: dat_nxt = {30'h00000000, mask_r};
                SBSEL_PARAM_ADDR: dat_nxt = {16'h0000, mem_rdata};
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // bank selection with holds
    // ****************************************
    logic [1:0] stored_bank, edit_bank;
    assign stored_bank = ctrl_r[SBSEL_CTRL_STORED_LSB +: 2];
    assign edit_bank = ctrl_r[SBSEL_CTRL_EDIT_LSB +: 2];

    always_comb
    begin
        // highest request wins, fall back to stored bank
        if (req_s[2])
            target = 2'h3;
        else if (req_s[1])
            target = 2'h2;
        else if (req_s[0])
            target = 2'h1;
        else
            target = stored_bank;
        // every enabled hold blocks
        hold = (ctrl_r[SBSEL_CTRL_BRK_BIT] && !brk_closed_s)
            || (ctrl_r[SBSEL_CTRL_OC_BIT] && oc_s)
            || (ctrl_r[SBSEL_CTRL_OV_BIT] && ov_s)
            || (ctrl_r[SBSEL_CTRL_UV_BIT] && uv_s)
            || (ctrl_r[SBSEL_CTRL_UF_BIT] && uf_s);
        active_nxt = active_r;
        pend_nxt = 1'b0;
        change_ev = 1'b0;
        held_ev = 1'b0;
        if (target != active_r)
        begin
            if (hold)
            begin
                pend_nxt = 1'b1;
                held_ev = !pend_r;
            end
            else
            begin
                active_nxt = target;
                change_ev = 1'b1;
            end
        end
    end

    // stored value always acts; it is written only while edit selects active bank
    logic edit_match_r, edit_match_nxt;
    assign edit_match_nxt = (edit_bank == active_r);
    logic [1:0] stored_eff;
    assign stored_eff = stored_bank;

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= SBSEL_CTRL_RST;
            irq_r <= SBSEL_IRQ_RST;
            mask_r <= SBSEL_MASK_RST;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            active_r <= SBSEL_BANK1;
            pend_r <= 1'b0;
            edit_match_r <= 1'b1;
        end
        else if (ce_in)
        begin
            // stored-bank write ignored unless editing the active bank
            ctrl_r <= (edit_match_r || ctrl_nxt[3:2] == active_r) ? ctrl_nxt
                      : {ctrl_nxt[8:2], ctrl_r[1:0]};
            irq_r <= irq_nxt;
            mask_r <= mask_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            active_r <= active_nxt;
            pend_r <= pend_nxt;
            edit_match_r <= edit_match_nxt;
        end
    end

    // ****************************************
    // parameter memory, read at active bank
    // ****************************************
    logic par_we;
    assign par_we = wb_wr && wb_adr_i == SBSEL_PARAM_ADDR && (&wb_sel_i[1:0]);
    sbsel_mem u_mem (
        .clk_in(clk_in),
        .ce_in(ce_in),
        .we_in(par_we),
        .waddr_in(edit_bank),
        .wdata_in(wb_dat_i[SBSEL_PW-1:0]),
        .raddr_in(active_r),
        .rdata_out(mem_rdata)
    );

    // ****************************************
    // outputs
    // ****************************************
    logic [3:0] led_r;
    logic ev_r, irq_o_r;
    logic [1:0] evb_r;
    logic [SBSEL_PW-1:0] par_r;
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            led_r <= 4'h1;
            ev_r <= 1'b0;
            evb_r <= 2'h0;
            irq_o_r <= 1'b0;
            par_r <= 16'h0000;
        end
        else if (ce_in)
        begin
            led_r <= 4'h1 << active_nxt;
            ev_r <= change_ev;
            evb_r <= active_nxt;
            irq_o_r <= |(irq_nxt & mask_nxt);
            par_r <= mem_rdata;
        end
    end
    assign bank_led_out = led_r;
    assign event_out = ev_r;
    assign event_bank_out = evb_r;
    assign irq_out = irq_o_r;
    assign elem_param_out = par_r;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ****************************************
    // assertions
    // ****************************************
    a_led_onehot: assert property (@(posedge clk_in) disable iff (!rst_n)
        $onehot(bank_led_out)) else $error("bank indicator not one-hot");
    a_led_tracks: assert property (@(posedge clk_in) disable iff (!rst_n)
        ce_in |=> bank_led_out == (4'h1 << active_r)) else $error("indicator lags bank");
    a_change_event: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && active_nxt != active_r) |=> event_out) else $error("change not logged");
    a_req_top: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && req_s[2] && !hold) |=> active_r == 2'h3) else $error("bank 4 not taken");
    a_hold_keeps: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && hold) |=> $stable(active_r)) else $error("bank changed under hold");
    a_brk_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && ctrl_r[SBSEL_CTRL_BRK_BIT] && !brk_closed_s) |=> $stable(active_r))
        else $error("bank changed with breaker open");
    a_oc_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && ctrl_r[5] && oc_s) |=> $stable(active_r)) else $error("oc hold broken");
    a_release: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && !hold && req_s == 3'h0) |=> active_r == $past(stored_eff))
        else $error("no fallback to stored bank");
    a_ov_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && ctrl_r[SBSEL_CTRL_OV_BIT] && ov_s) |=> $stable(active_r))
        else $error("overvoltage hold broken");
    a_uv_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && ctrl_r[SBSEL_CTRL_UV_BIT] && uv_s) |=> $stable(active_r))
        else $error("undervoltage hold broken");
    a_uf_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && ctrl_r[SBSEL_CTRL_UF_BIT] && uf_s) |=> $stable(active_r))
        else $error("underfrequency hold broken");
    a_event_bank: assert property (@(posedge clk_in) disable iff (!rst_n)
        (ce_in && change_ev) |=> (event_out && event_bank_out == active_r))
        else $error("event carries wrong bank");
    c_held_irq: cover property (@(posedge clk_in) disable iff (!rst_n)
        irq_r[SBSEL_IRQ_HELD_BIT]);
    c_hold_then_apply: cover property (@(posedge clk_in) disable iff (!rst_n)
        pend_r ##1 event_out);
    c_bank4: cover property (@(posedge clk_in) disable iff (!rst_n) bank_led_out == 4'h8);
    c_irq: cover property (@(posedge clk_in) disable iff (!rst_n) irq_out);
endmodule
`default_nettype wire

// ---- verif/sbsel_plant.sv ----
// far-side model: breaker state and element pickups driven from test commands
`timescale 1ns/1ps
`default_nettype none
module sbsel_plant
(
    input wire logic clk_in, // clock
    input wire logic [4:0] cond_in, // bit0 breaker open, bits 1..4 oc ov uv uf picked
    output logic breaker_closed_out, // high while breaker closed
    output logic oc_out, // overcurrent picked
    output logic ov_out, // overvoltage picked
    output logic uv_out, // undervoltage picked
    output logic uf_out // underfrequency picked
);
    // pins change only after a clock edge, like a relay contact scanned by the device
    always_ff @(posedge clk_in)
    begin
        breaker_closed_out <= ~cond_in[0];
        {uf_out, uv_out, ov_out, oc_out} <= cond_in[4:1];
    end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking testbench of the settings bank selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import sbsel_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [SBSEL_AW-1:0] adr = '0;
    logic [31:0] dat = '0;
    logic [31:0] rd;
    logic [31:0] dato;
    logic [2:0] req = '0;
    logic [4:0] cond = '0;
    logic brk, oc, ov, uv, uf, ev, irq, ack;
    logic [3:0] led;
    logic [1:0] evb;
    logic [SBSEL_PW-1:0] par;
    int failures = 0;
    int compares = 0;
    int events = 0;
    int nev = 0;
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) if (ev === 1'b1) events <= events + 1;
    sbsel_plant sbsel_plant_i (.clk_in(clk_in), .cond_in(cond), .breaker_closed_out(brk),
        .oc_out(oc), .ov_out(ov), .uv_out(uv), .uf_out(uf));
    sbsel_top sbsel_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(dato), .wb_ack_o(ack), .bank_req_in(req), .breaker_closed_in(brk),
        .oc_picked_in(oc), .ov_picked_in(ov), .uv_picked_in(uv), .uf_picked_in(uf),
        .bank_led_out(led), .elem_param_out(par), .event_out(ev), .event_bank_out(evb),
        .irq_out(irq));
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one classic cycle; read data lands in rd
    task automatic wb(input logic w, input logic [SBSEL_AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rd = dato;
        {cyc, stb} <= 2'b00;
        if (n >= 50)
        begin
            failures++;
            tally_and_finish();
        end
        @(posedge clk_in);
    endtask
    task automatic settle();
        repeat (6) @(posedge clk_in);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_in);
        failures++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        `CHK("led", 4'h1, led)
        wb(0, SBSEL_CTRL_ADDR, 0);
        `CHK("ctrl", {23'h0, SBSEL_CTRL_RST}, rd)
        wb(0, 4'hF, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        for (int k = 0; k < 4; k++)
        begin
            wb(1, SBSEL_CTRL_ADDR, k << SBSEL_CTRL_EDIT_LSB);
            wb(1, SBSEL_PARAM_ADDR, 32'hA50 + k);
        end
        wb(1, SBSEL_CTRL_ADDR, 32'h6);
        settle();
        `CHK("refused", 4'h1, led)
        wb(1, SBSEL_CTRL_ADDR, 0);
        wb(1, SBSEL_MASK_ADDR, 1);
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            wb(1, SBSEL_CTRL_ADDR, ((i + 1) % 4) | (i << SBSEL_CTRL_EDIT_LSB));
            settle();
            nev++;
            `CHK("led", 4'h1 << ((i + 1) % 4), led)
            `CHK("param", 16'hA50 + ((i + 1) % 4), par)
            wb(0, SBSEL_PARAM_ADDR, 0);
            `CHK("param rd", 32'hA50 + ((i + 1) % 4), rd)
        end
        `CHK("irq", 1'b1, irq)
        wb(1, SBSEL_IRQ_ADDR, 3);
        wb(1, SBSEL_MASK_ADDR, 0);
        settle();
        `CHK("irq clr", 1'b0, irq)
        $display("test stored bank done");
        for (int i = 0; i < 6; i++)
        begin
            req <= 3'(int'(18'o137310 >> (3 * (5 - i))) & 7);
            settle();
            nev++;
            `CHK("led", 4'h1 << (i < 3 ? i + 1 : 5 - i), led)
            `CHK("evbank", 2'(i < 3 ? i + 1 : 5 - i), evb)
            wb(0, SBSEL_STAT_ADDR, 0);
            `CHK("status", 2'(i < 3 ? i + 1 : 5 - i), rd[1:0])
        end
        `CHK("irq masked", 1'b0, irq)
        wb(0, SBSEL_IRQ_ADDR, 0);
        `CHK("irq st", 1'b1, rd[SBSEL_IRQ_CHANGE_BIT])
        $display("test request pins done");
        for (int i = 0; i < 5; i++)
        begin
            wb(1, SBSEL_CTRL_ADDR, 1 << (SBSEL_CTRL_BRK_BIT + i));
            req <= 3'h1;
            settle();
            cond[i] <= 1'b1;
            settle();
            req <= 3'h0;
            settle();
            `CHK("held", 4'h2, led)
            wb(0, SBSEL_STAT_ADDR, 0);
            `CHK("pending", 1'b1, rd[11])
            cond[i] <= 1'b0;
            settle();
            nev += 2;
            `CHK("applied", 4'h1, led)
        end
        wb(0, SBSEL_IRQ_ADDR, 0);
        `CHK("irq held", 1'b1, rd[SBSEL_IRQ_HELD_BIT])
        $display("test single holds done");
        wb(1, SBSEL_CTRL_ADDR, 3 << SBSEL_CTRL_OC_BIT);
        req <= 3'h1;
        settle();
        cond <= 5'h0E;
        settle();
        req <= 3'h0;
        settle();
        cond <= 5'h0C;
        settle();
        `CHK("one hold left", 4'h2, led)
        cond <= 5'h08;
        settle();
        nev += 2;
        `CHK("all clear", 4'h1, led)
        $display("test combined holds done");
        ce <= 1'b0;
        req <= 3'h4;
        settle();
        `CHK("frozen", 4'h1, led)
        ce <= 1'b1;
        settle();
        nev++;
        `CHK("bank4", 4'h8, led)
        req <= 3'h0;
        settle();
        nev++;
        `CHK("back to 1", 4'h1, led)
        `CHK("events", nev, events)
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
